// ### txsyn_ctrl_regs.sv
`timescale 1ns/10ps
`default_nettype none
module txsyn_ctrl_regs
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic shiftClk,
   input wire logic csN,
   input wire logic serialIn,
   input wire logic txRxSelect,
   input wire logic shutdownN,
   input wire logic antennaSelect,
   input wire logic [5:0] parallelGainPins,
   output logic txEnable,
   output logic paEnable,
   output logic antennaPortB,
   output logic [1:0] txLpfCoarse,
   output logic [2:0] txLpfFine,
   output logic [5:0] txGainCode,
   output logic [5:0] txAttenHalfDb,
   output logic [2:0] paBiasStage1,
   output logic [3:0] paBiasStage2,
   output logic [1:0] monitorSelect,
   output logic monitorPowerDet,
   output logic refDivBy2,
   output logic [7:0] synthIntDiv,
   output logic [19:0] synthFracDiv
);
   localparam int N = txsyn_pkg::PIN_COUNT;

   logic [txsyn_pkg::WORD_W-1:0] shiftWord;
   logic [N-1:0] pinRaw;
   logic [N-1:0] syncA_ff;
   logic [N-1:0] syncB_ff;
   logic [N-1:0] syncC_ff;
   logic [N-1:0] pinStable_ff;
   logic [N-1:0] nxt_pinStable;

   txsyn_shifter u_shifter
   (
      .shiftClk(shiftClk),
      .csN(csN),
      .serialIn(serialIn),
      .shiftWord(shiftWord)
   );

   assign pinRaw = {parallelGainPins, antennaSelect, shutdownN, txRxSelect, csN};

   // a change counts once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_pin
         always_comb
         begin
            nxt_pinStable[gi] = pinStable_ff[gi];
            if (syncB_ff[gi] == syncC_ff[gi])
            begin
               nxt_pinStable[gi] = syncC_ff[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncA_ff <= txsyn_pkg::PIN_RESET;
         syncB_ff <= txsyn_pkg::PIN_RESET;
         syncC_ff <= txsyn_pkg::PIN_RESET;
         pinStable_ff <= txsyn_pkg::PIN_RESET;
      end
      else
      begin
         syncA_ff <= pinRaw;
         syncB_ff <= syncA_ff;
         syncC_ff <= syncB_ff;
         pinStable_ff <= nxt_pinStable;
      end
   end

   logic csStable;
   logic txRxStable;
   logic shdnStable;
   logic antSelStable;
   logic [5:0] pinGainStable;
   assign csStable = pinStable_ff[0];
   assign txRxStable = pinStable_ff[1];
   assign shdnStable = pinStable_ff[2];
   assign antSelStable = pinStable_ff[3];
   assign pinGainStable = pinStable_ff[9:4];

   // register bank
   logic csPrev_ff;
   logic [13:0] synthIntegerDivider_ff;
   logic [13:0] synthFractionUpper_ff;
   logic [13:0] synthConfig_ff;
   logic [13:0] lpfFine_ff;
   logic [13:0] lpfMonitor_ff;
   logic [13:0] gainConfig_ff;
   logic [13:0] paConfig_ff;
   logic [13:0] txGainReg_ff;
   logic nxt_csPrev;
   logic [13:0] nxt_synthInt;
   logic [13:0] nxt_synthFrac;
   logic [13:0] nxt_synthCfg;
   logic [13:0] nxt_lpfFine;
   logic [13:0] nxt_lpfMon;
   logic [13:0] nxt_gainCfg;
   logic [13:0] nxt_paCfg;
   logic [13:0] nxt_txGainReg;
   logic [3:0] wrAddr;
   logic [13:0] wrData;
   logic wrStrobe;

   // shift word is frozen while select is high, so it is sampled here directly
   assign wrAddr = shiftWord[txsyn_pkg::ADDR_W-1:0];
   assign wrData = shiftWord[txsyn_pkg::WORD_W-1:txsyn_pkg::ADDR_W];
   assign wrStrobe = csStable & ~csPrev_ff;

   always_comb
   begin
      nxt_csPrev = csStable;
      nxt_synthInt = synthIntegerDivider_ff;
      nxt_synthFrac = synthFractionUpper_ff;
      nxt_synthCfg = synthConfig_ff;
      nxt_lpfFine = lpfFine_ff;
      nxt_lpfMon = lpfMonitor_ff;
      nxt_gainCfg = gainConfig_ff;
      nxt_paCfg = paConfig_ff;
      nxt_txGainReg = txGainReg_ff;
      // unaddressed registers hold; unused addresses are dropped
      if (wrStrobe)
      begin
         unique case (wrAddr)
            txsyn_pkg::ADDR_SYNTH_INT: nxt_synthInt = wrData;
            txsyn_pkg::ADDR_SYNTH_FRAC: nxt_synthFrac = wrData;
            txsyn_pkg::ADDR_SYNTH_CFG: nxt_synthCfg = wrData;
            txsyn_pkg::ADDR_LPF_FINE: nxt_lpfFine = wrData;
            txsyn_pkg::ADDR_LPF_MON: nxt_lpfMon = wrData;
            txsyn_pkg::ADDR_GAIN_CFG: nxt_gainCfg = wrData;
            txsyn_pkg::ADDR_PA_CFG: nxt_paCfg = wrData;
            txsyn_pkg::ADDR_TX_GAIN: nxt_txGainReg = wrData;
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         csPrev_ff <= 1'b1;
         synthIntegerDivider_ff <= txsyn_pkg::RST_SYNTH_INT;
         synthFractionUpper_ff <= txsyn_pkg::RST_SYNTH_FRAC;
         synthConfig_ff <= txsyn_pkg::RST_SYNTH_CFG;
         lpfFine_ff <= txsyn_pkg::RST_LPF_FINE;
         lpfMonitor_ff <= txsyn_pkg::RST_LPF_MON;
         gainConfig_ff <= txsyn_pkg::RST_GAIN_CFG;
         paConfig_ff <= txsyn_pkg::RST_PA_CFG;
         txGainReg_ff <= txsyn_pkg::RST_TX_GAIN;
      end
      else
      begin
         csPrev_ff <= nxt_csPrev;
         synthIntegerDivider_ff <= nxt_synthInt;
         synthFractionUpper_ff <= nxt_synthFrac;
         synthConfig_ff <= nxt_synthCfg;
         lpfFine_ff <= nxt_lpfFine;
         lpfMonitor_ff <= nxt_lpfMon;
         gainConfig_ff <= nxt_gainCfg;
         paConfig_ff <= nxt_paCfg;
         txGainReg_ff <= nxt_txGainReg;
      end
   end

   // transmit control and output registers
   logic txEnable_ff;
   logic paEnable_ff;
   logic antennaPortB_ff;
   logic [5:0] txGain_ff;
   logic [5:0] atten_ff;
   logic [7:0] paDelayCnt_ff;
   logic nxt_txEnable;
   logic nxt_paEnable;
   logic nxt_antennaPortB;
   logic [5:0] nxt_txGain;
   logic [5:0] nxt_atten;
   logic [7:0] nxt_paDelayCnt;
   logic [5:0] gainSel;
   logic [3:0] paDelayCode;
   logic [15:0] paDelayTarget;

   assign paDelayCode = paConfig_ff[txsyn_pkg::PA_DLY_LSB +: 4];
   // linear from 200 ns at code 0 to 7 us at code 15
   assign paDelayTarget = 16'(txsyn_pkg::PA_DELAY_MIN_CYC)
      + 16'((32'(paDelayCode) * 32'(txsyn_pkg::PA_DELAY_MAX_CYC - txsyn_pkg::PA_DELAY_MIN_CYC))
      / 32'(txsyn_pkg::PA_DELAY_CODES_M1));

   always_comb
   begin
      nxt_txEnable = txRxStable & shdnStable;
      // transmit overrides the antenna select input
      nxt_antennaPortB = nxt_txEnable ? 1'b1 : antSelStable;
      // only the selected gain source reaches the output
      gainSel = gainConfig_ff[txsyn_pkg::GAIN_SRC_BIT]
         ? txGainReg_ff[5:0] : pinGainStable;
      nxt_txGain = gainSel;
      // attenuation below maximum, in half decibels
      if (gainSel >= txsyn_pkg::GAIN_HALF_STEP_MIN)
      begin
         nxt_atten = 6'h3F - gainSel;
      end
      else
      begin
         nxt_atten = txsyn_pkg::GAIN_PAIR_BASE_HALF_DB
            + ((txsyn_pkg::GAIN_PAIR_TOP - gainSel) & 6'h3E);
      end
      nxt_paDelayCnt = paDelayCnt_ff;
      nxt_paEnable = paEnable_ff;
      // counter restarts whenever transmit drops
      if (!nxt_txEnable)
      begin
         nxt_paDelayCnt = 8'h00;
         nxt_paEnable = 1'b0;
      end
      else if (!paEnable_ff)
      begin
         // target counted in whole cycles of transmit enable
         if (16'(paDelayCnt_ff) >= paDelayTarget)
         begin
            nxt_paEnable = 1'b1;
         end
         else
         begin
            nxt_paDelayCnt = paDelayCnt_ff + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txEnable_ff <= 1'b0;
         paEnable_ff <= 1'b0;
         antennaPortB_ff <= 1'b0;
         txGain_ff <= 6'h00;
         atten_ff <= 6'h3F;
         paDelayCnt_ff <= 8'h00;
      end
      else
      begin
         txEnable_ff <= nxt_txEnable;
         paEnable_ff <= nxt_paEnable;
         antennaPortB_ff <= nxt_antennaPortB;
         txGain_ff <= nxt_txGain;
         atten_ff <= nxt_atten;
         paDelayCnt_ff <= nxt_paDelayCnt;
      end
   end

   // every output straight from a register
   assign txEnable = txEnable_ff;
   assign paEnable = paEnable_ff;
   assign antennaPortB = antennaPortB_ff;
   assign txGainCode = txGain_ff;
   assign txAttenHalfDb = atten_ff;
   assign txLpfCoarse = lpfMonitor_ff[txsyn_pkg::COARSE_LSB +: 2];
   assign txLpfFine = lpfFine_ff[txsyn_pkg::FINE_LSB +: 3];
   assign paBiasStage1 = paConfig_ff[txsyn_pkg::BIAS1_LSB +: 3];
   assign paBiasStage2 = paConfig_ff[txsyn_pkg::BIAS2_LSB +: 4];
   assign monitorSelect = lpfMonitor_ff[txsyn_pkg::MON_LSB +: 2];
   assign refDivBy2 = synthConfig_ff[txsyn_pkg::REF_DIV_BIT];
   assign synthIntDiv = synthIntegerDivider_ff[txsyn_pkg::INT_LSB +: 8];
   assign synthFracDiv = {synthFractionUpper_ff,
      synthIntegerDivider_ff[txsyn_pkg::FRAC_LOW_LSB +: 6]};

   // registered alongside the monitor field
   logic monPowerDet_ff;
   logic nxt_monPowerDet;
   always_comb
   begin
      nxt_monPowerDet = (nxt_lpfMon[txsyn_pkg::MON_LSB +: 2]
         == txsyn_pkg::MON_POWER_DET);
   end
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         monPowerDet_ff <= 1'b0;
      end
      else
      begin
         monPowerDet_ff <= nxt_monPowerDet;
      end
   end
   assign monitorPowerDet = monPowerDet_ff;
endmodule : txsyn_ctrl_regs
`default_nettype wire

// ### txsyn_pkg.sv
// Overview of operation
// - transmit enabled only when select and shutdown_n high
// - transmit always routes PA to antenna port B
// - register 8 bits 1:0 pick transmit corner
// - register 7 bits 5:3 fine-scale the corner
// - six-bit gain from register 12 or pins
// - gain spans 31 dB, half then whole steps
// - register 10 holds both PA bias fields
// - PA turns on programmable delay after select
// - monitor field 10 routes PA power detector
// - register 5 bit 2 sets reference divide
// - register 3 low byte holds integer divider
// - fraction split over registers 4 and 3
// - write word is 14 data plus 4 address
// - shift MSB first, latch on select rise
// - keep last 18 bits, no pulse count
`default_nettype none
package txsyn_pkg;
   localparam int WORD_W = 18;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 14;
   localparam logic [3:0] ADDR_SYNTH_INT = 4'h3;
   localparam logic [3:0] ADDR_SYNTH_FRAC = 4'h4;
   localparam logic [3:0] ADDR_SYNTH_CFG = 4'h5;
   localparam logic [3:0] ADDR_LPF_FINE = 4'h7;
   localparam logic [3:0] ADDR_LPF_MON = 4'h8;
   localparam logic [3:0] ADDR_GAIN_CFG = 4'h9;
   localparam logic [3:0] ADDR_PA_CFG = 4'hA;
   localparam logic [3:0] ADDR_TX_GAIN = 4'hC;
   localparam logic [13:0] RST_SYNTH_INT = 14'h0079;
   localparam logic [13:0] RST_SYNTH_FRAC = 14'h3666;
   localparam logic [13:0] RST_SYNTH_CFG = 14'h00A4;
   localparam logic [13:0] RST_LPF_FINE = 14'h1022;
   localparam logic [13:0] RST_LPF_MON = 14'h2021;
   localparam logic [13:0] RST_GAIN_CFG = 14'h03B5;
   localparam logic [13:0] RST_PA_CFG = 14'h1DA4;
   localparam logic [13:0] RST_TX_GAIN = 14'h0140;
   localparam int COARSE_LSB = 0;
   localparam int FINE_LSB = 3;
   localparam int MON_LSB = 8;
   localparam logic [1:0] MON_POWER_DET = 2'h2;
   localparam int GAIN_SRC_BIT = 10;
   localparam int REF_DIV_BIT = 2;
   localparam int BIAS1_LSB = 0;
   localparam int BIAS2_LSB = 3;
   localparam int PA_DLY_LSB = 10;
   localparam int INT_LSB = 0;
   localparam int FRAC_LOW_LSB = 8;
   localparam logic [5:0] GAIN_HALF_STEP_MIN = 6'h30;
   localparam logic [5:0] GAIN_PAIR_TOP = 6'h2F;
   localparam logic [5:0] GAIN_PAIR_BASE_HALF_DB = 6'h10;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PA_DELAY_MIN_NS = 200;
   localparam int PA_DELAY_MAX_NS = 7000;
   localparam int PA_DELAY_CODES_M1 = 15;
   localparam int PA_DELAY_MIN_CYC = (PA_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PA_DELAY_MAX_CYC = PA_DELAY_MAX_NS / CLK_PERIOD_NS;
   localparam int PIN_COUNT = 10;
   // csN, txRxSelect, shutdownN, antennaSelect, gain[5:0]
   localparam logic [9:0] PIN_RESET = 10'h001;
endpackage : txsyn_pkg
`default_nettype wire

// ### txsyn_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module txsyn_shifter
(
   input wire logic shiftClk,
   input wire logic csN,
   input wire logic serialIn,
   output logic [txsyn_pkg::WORD_W-1:0] shiftWord
);
   logic [txsyn_pkg::WORD_W-1:0] shift_ff;
   logic [txsyn_pkg::WORD_W-1:0] nxt_shift;

   // link has no reset; only the last 18 bits are kept
   always_comb
   begin
      nxt_shift = shift_ff;
      if (!csN)
      begin
         nxt_shift = {shift_ff[txsyn_pkg::WORD_W-2:0], serialIn};
      end
   end

   always_ff @(posedge shiftClk)
   begin
      shift_ff <= nxt_shift;
   end

   assign shiftWord = shift_ff;
endmodule : txsyn_shifter
`default_nettype wire

// ### txsyn_properties.sv
`timescale 1ns/10ps
`default_nettype none
module txsyn_ctrl_chk
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic csN,
   input wire logic txRxSelect,
   input wire logic shutdownN,
   input wire logic txEnable,
   input wire logic paEnable,
   input wire logic antennaPortB,
   input wire logic [1:0] txLpfCoarse,
   input wire logic [2:0] txLpfFine,
   input wire logic [5:0] txGainCode,
   input wire logic [5:0] txAttenHalfDb,
   input wire logic [1:0] monitorSelect,
   input wire logic monitorPowerDet,
   input wire logic [19:0] synthFracDiv
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   function automatic logic [5:0] atten(input logic [5:0] g);
      return (g >= 6'h30) ? 6'h3F - g : 6'h10 + ((6'h2F - g) & 6'h3E);
   endfunction : atten
   sequence sTxOff;
      (!txRxSelect) [*8];
   endsequence
   sequence sTxOn;
      (txRxSelect && shutdownN) [*8];
   endsequence
   sequence sIdle;
      csN [*8];
   endsequence
   AST_TX_OFF: assert property (sTxOff |-> !txEnable)
      else $error("transmit on with select low");
   AST_TX_ON: assert property (sTxOn |-> txEnable)
      else $error("transmit off with pins high");
   AST_ANT_B: assert property (txEnable |-> antennaPortB)
      else $error("antenna port b off in transmit");
   AST_PA_IN_TX: assert property (paEnable |-> txEnable)
      else $error("pa on outside transmit");
   AST_PA_MIN: assert property ($rose(txEnable) |-> !paEnable [*3])
      else $error("pa on too early");
   AST_PA_MAX: assert property ($rose(txEnable)
      |-> ##[1:142] (paEnable || !txEnable))
      else $error("pa on too late");
   AST_MON_DET: assert property (monitorPowerDet == (monitorSelect == 2'h2))
      else $error("power detector routing wrong");
   AST_HOLD: assert property (sIdle
      |-> $stable({txLpfCoarse, txLpfFine, synthFracDiv}))
      else $error("register changed without frame");
   AST_ATTEN: assert property ($stable(txGainCode) [*3]
      |-> txAttenHalfDb == atten(txGainCode))
      else $error("attenuation mismatch");
endmodule : txsyn_ctrl_chk
bind txsyn_ctrl_regs txsyn_ctrl_chk u_chk (.clk, .nrst, .csN, .txRxSelect, .shutdownN,
   .txEnable, .paEnable, .antennaPortB, .txLpfCoarse, .txLpfFine, .txGainCode,
   .txAttenHalfDb, .monitorSelect, .monitorPowerDet, .synthFracDiv);
`default_nettype wire

// ### txsyn_baseband.sv
`timescale 1ns/10ps
`default_nettype none
module txsyn_baseband
(
   output logic shiftClk,
   output logic csN,
   output logic serialIn,
   output logic [5:0] parallelGainPins
);
   initial
   begin
      shiftClk = 1'b0;
      csN = 1'b1;
      serialIn = 1'b0;
      parallelGainPins = 6'h00;
   end
   // clock runs only inside the frame
   task automatic send(input int n, input logic [17:0] w);
      int i;
      csN = 1'b0;
      for (i = n - 1; i >= 0; i--)
      begin
         serialIn = w[i];
         #24 shiftClk = 1'b1;
         #24 shiftClk = 1'b0;
      end
      #24 csN = 1'b1;
      serialIn = ~serialIn;
      #400;
   endtask : send
   task automatic set_gain(input logic [5:0] g);
      parallelGainPins = g;
   endtask : set_gain
endmodule : txsyn_baseband
`default_nettype wire

// ### txsyn_ctrl_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module txsyn_ctrl_regs_tb;
   logic clk, nrst, txRxSelect, shutdownN, antennaSelect;
   wire logic shiftClk, csN, serialIn;
   wire logic [5:0] parallelGainPins;
   logic txEnable, paEnable, antennaPortB, monitorPowerDet, refDivBy2;
   logic [1:0] txLpfCoarse, monitorSelect;
   logic [2:0] txLpfFine, paBiasStage1;
   logic [3:0] paBiasStage2;
   logic [5:0] txGainCode, txAttenHalfDb;
   logic [7:0] synthIntDiv;
   logic [19:0] synthFracDiv;
   int badCount = 0;
   int comparisons = 0;
   txsyn_baseband u_txsyn_baseband (.shiftClk, .csN, .serialIn, .parallelGainPins);
   txsyn_ctrl_regs u_txsyn_ctrl_regs (.clk, .nrst, .shiftClk, .csN, .serialIn, .txRxSelect,
      .shutdownN, .antennaSelect, .parallelGainPins, .txEnable, .paEnable, .antennaPortB,
      .txLpfCoarse, .txLpfFine, .txGainCode, .txAttenHalfDb, .paBiasStage1, .paBiasStage2,
      .monitorSelect, .monitorPowerDet, .refDivBy2, .synthIntDiv, .synthFracDiv);
   task automatic give_verdict;
      if (badCount == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      comparisons++;
      if (g !== e)
      begin
         badCount++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [13:0] d);
      u_txsyn_baseband.send(18, {d, a});
      @(posedge clk);
      #5;
   endtask : wr
   task automatic pins(input logic t, input logic s, input logic a);
      @(posedge clk);
      #5;
      txRxSelect = t;
      shutdownN = s;
      antennaSelect = a;
      repeat (8) @(posedge clk);
      #5;
   endtask : pins
   task automatic t_fields;
      int i;
      for (i = 0; i < 4; i++)
      begin
         wr(4'h8, {4'h0, i[1:0], 6'h00, i[1:0]});
         chk("coarse", i[1:0], txLpfCoarse);
         chk("monSel", i[1:0], monitorSelect);
         chk("powerDet", i[1:0] == 2'h2, monitorPowerDet);
      end
      for (i = 0; i < 6; i++)
      begin
         wr(4'h7, {8'h40, i[2:0], 3'h2});
         chk("fine", i[2:0], txLpfFine);
      end
      wr(4'h3, 14'h3F40);
      wr(4'h4, 14'h1234);
      chk("intDiv", 8'h40, synthIntDiv);
      chk("frac", {14'h1234, 6'h3F}, synthFracDiv);
      wr(4'h3, 14'h00FF);
      chk("intDivTop", 8'hFF, synthIntDiv);
      chk("fracLow", {14'h1234, 6'h00}, synthFracDiv);
      wr(4'h5, 14'h0000);
      chk("refDiv", 1'b0, refDivBy2);
      wr(4'h5, 14'h0004);
      chk("refDiv", 1'b1, refDivBy2);
      wr(4'hA, 14'h005D);
      chk("bias1", 3'h5, paBiasStage1);
      chk("bias2", 4'hB, paBiasStage2);
      wr(4'hB, 14'h3FFF);
      wr(4'h6, 14'h3FFF);
      chk("unmapped", 3'h5, txLpfFine);
   endtask : t_fields
   task automatic t_short;
      wr(4'h8, 14'h0000);
      u_txsyn_baseband.send(10, {8'h00, 6'h03, 4'h8});
      @(posedge clk);
      #5;
      chk("shortCoarse", 2'h3, txLpfCoarse);
      chk("shortMon", 2'h2, monitorSelect);
   endtask : t_short
   task automatic t_gain;
      u_txsyn_baseband.set_gain(6'h2A);
      wr(4'h9, 14'h0000);
      wr(4'hC, 14'h0015);
      chk("gainPins", 6'h2A, txGainCode);
      u_txsyn_baseband.set_gain(6'h01);
      wr(4'h9, 14'h0400);
      chk("gainReg", 6'h15, txGainCode);
      wr(4'hC, 14'h0030);
      chk("atten", 6'h0F, txAttenHalfDb);
      wr(4'hC, 14'h0000);
      chk("attenMin", 6'h3E, txAttenHalfDb);
   endtask : t_gain
   task automatic t_pa(input logic [3:0] code);
      int n;
      wr(4'hA, {code, 10'h05D});
      pins(1'b1, 1'b0, 1'b1);
      chk("txShdn", 1'b0, txEnable);
      chk("antRx", 1'b1, antennaPortB);
      pins(1'b0, 1'b1, 1'b1);
      txRxSelect = 1'b1;
      n = 0;
      while (txEnable !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #5;
         n++;
      end
      chk("txOn", 1'b1, txEnable);
      chk("antB", 1'b1, antennaPortB);
      n = 0;
      while (paEnable !== 1'b1 && n < 200)
      begin
         @(posedge clk);
         #5;
         n++;
      end
      chk("paDelay", 4 + code * 136 / 15, n);
      pins(1'b0, 1'b1, 1'b0);
      chk("paOff", 1'b0, paEnable);
      chk("antOff", 1'b0, antennaPortB);
   endtask : t_pa
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      #3000000;
      badCount++;
      give_verdict();
   end
   initial
   begin
      nrst = 1'b0;
      txRxSelect = 1'b0;
      shutdownN = 1'b0;
      antennaSelect = 1'b0;
      repeat (2) @(posedge clk);
      #5;
      nrst = 1'b1;
      repeat (6) @(posedge clk);
      #5;
      chk("rstFine", txsyn_pkg::RST_LPF_FINE[5:3], txLpfFine);
      t_fields();
      t_short();
      t_gain();
      t_pa(4'h0);
      t_pa(4'hF);
      give_verdict();
   end
endmodule : txsyn_ctrl_regs_tb
`default_nettype wire
